// [pkg/fpbp_pkg.sv]
// Constants and types for the flash page buffer programmer
// Functional notes
// - Clear command wipes buffer and flags
// - Command write clears status; reads return status
// - Data write stores byte, sets flag
// - Address low six bits auto-increment, wrap
// - Any rewritten address position is honoured
// - Page from high/low; only flagged bytes change
// - Erase-program command starts cycle, stalls processor
// - Status valid when idle state ends
// - Interrupt aborts cycle, sets interrupted flag
// - Cycle lasts 4 ms: 2 erase, 2 program
// - Brown-out blocks erase and program
// - 64-byte pages, 1 to 64 bytes
// - Secured sectors refuse erase-program
// - Status at e4h, reset zero, bits 3:0
// - Secured target sets security violation flag
// - Interrupt or brown-out sets high-voltage abort
`default_nettype none
package fpbp_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] FPBP_CMDSTAT_OFS = 8'he4;
   localparam logic [7:0] FPBP_ADRL_OFS    = 8'he8;
   localparam logic [7:0] FPBP_ADRH_OFS    = 8'hec;
   localparam logic [7:0] FPBP_WDATA_OFS   = 8'hf0;
   localparam logic [7:0] FPBP_SECURE_OFS  = 8'hf4;
   localparam logic [7:0] FPBP_CMDSTAT_RST = 8'h00;
   localparam logic [7:0] FPBP_ADR_RST     = 8'h00;
   localparam logic [7:0] FPBP_SECURE_RST  = 8'h00;
   // ----------------------------------------------------------------
   // Commands and status bit positions
   // ----------------------------------------------------------------
   localparam logic [7:0] FPBP_CMD_LOAD    = 8'h00;
   localparam logic [7:0] FPBP_CMD_EP      = 8'h68;
   localparam int         FPBP_OI_BIT      = 0;
   localparam int         FPBP_SV_BIT      = 1;
   localparam int         FPBP_HVE_BIT     = 2;
   localparam int         FPBP_HVA_BIT     = 3;
   localparam int         FPBP_PAGE_BYTES  = 64;
   localparam int         FPBP_PAGES_PER_SECTOR = 16;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int         FPBP_CLK_HZ      = 40000000;
   localparam int         FPBP_ERASE_MS    = 2;
   localparam int         FPBP_PROG_MS     = 2;
   localparam int         FPBP_ERASE_CYC   = FPBP_CLK_HZ / 1000 * FPBP_ERASE_MS;
   localparam int         FPBP_PROG_CYC    = FPBP_CLK_HZ / 1000 * FPBP_PROG_MS;

   typedef enum logic [1:0] {
      FPBP_IDLE  = 2'b00,
      FPBP_ERASE = 2'b01,
      FPBP_PROG  = 2'b10
   } fpbp_state_type;

   typedef struct packed {
      logic [7:0] adr_high;
      logic [7:0] adr_low;
   } fpbp_page_type;
endpackage
`default_nettype wire

// [design/fpbp_top.sv]
// Flash page buffer programmer: APB registers, page buffer and cycle timing
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fpbp_top
   import fpbp_pkg::*;
#(
   parameter int ERASE_CYC = FPBP_ERASE_CYC,
   parameter int PROG_CYC  = FPBP_PROG_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        irq_pending,
   input  wire logic        flash_brownout_detect,
   input  wire logic        hv_generator_error,
   output logic             cpu_program_idle,
   output logic             flash_erase_en,
   output logic             flash_program_en,
   output logic [7:0]       flash_byte_index,
   output logic [7:0]       flash_byte_data,
   output logic             flash_byte_we,
   output logic [15:0]      flash_page_addr
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0]     buf_q [FPBP_PAGE_BYTES];
   logic [63:0]    upd_q;
   logic [7:0]     adrl_q;
   logic [7:0]     adrh_q;
   logic [7:0]     secure_q;
   logic [3:0]     stat_q;
   fpbp_state_type st_q;
   logic [22:0]    cnt_q;
   logic [6:0]     idx_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   wire logic busy   = (st_q != FPBP_IDLE);
   // Access counts only at the edge where pready is seen high
   wire logic acc    = psel & penable & pready;
   wire logic wr     = acc & pwrite;
   wire logic wr_cmd = wr & hit(paddr, FPBP_CMDSTAT_OFS);
   wire logic wr_adl = wr & hit(paddr, FPBP_ADRL_OFS) & ~busy;
   wire logic wr_adh = wr & hit(paddr, FPBP_ADRH_OFS) & ~busy;
   wire logic wr_dat = wr & hit(paddr, FPBP_WDATA_OFS) & ~busy;
   wire logic wr_sec = wr & hit(paddr, FPBP_SECURE_OFS) & ~busy;
   wire logic mapped = hit(paddr, FPBP_CMDSTAT_OFS) | hit(paddr, FPBP_ADRL_OFS)
                     | hit(paddr, FPBP_ADRH_OFS) | hit(paddr, FPBP_WDATA_OFS)
                     | hit(paddr, FPBP_SECURE_OFS);
   wire logic cmd_load = wr_cmd & ~busy & (pwdata[7:0] == FPBP_CMD_LOAD);
   wire logic cmd_ep   = wr_cmd & ~busy & (pwdata[7:0] == FPBP_CMD_EP);
   // Sixteen pages per sector; sectors above the mask width stay locked
   wire logic [5:0] sector = adrh_q[7:2];
   wire logic sec_blocked  = secure_q[sector[2:0]] | (sector[5:3] != 3'h0);
   wire logic abort_ev = irq_pending | flash_brownout_detect;
   wire logic cnt_done = (cnt_q == 23'h000000);

   // ----------------------------------------------------------------
   // APB answer: zero wait, error on unmapped
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= 32'h00000000;
         if (psel & ~penable & ~pwrite) begin
            if (hit(paddr, FPBP_CMDSTAT_OFS))
               prdata <= {28'h0000000, stat_q};
            else if (hit(paddr, FPBP_ADRL_OFS))
               prdata <= {24'h000000, adrl_q};
            else if (hit(paddr, FPBP_ADRH_OFS))
               prdata <= {24'h000000, adrh_q};
            else if (hit(paddr, FPBP_SECURE_OFS))
               prdata <= {24'h000000, secure_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // Address registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adrl_q   <= FPBP_ADR_RST;
         adrh_q   <= FPBP_ADR_RST;
         secure_q <= FPBP_SECURE_RST;
      end else begin
         if (wr_adl)
            adrl_q <= pwdata[7:0];
         else if (wr_dat)
            adrl_q <= {adrl_q[7:6], adrl_q[5:0] + 6'h01};
         if (wr_adh)
            adrh_q <= pwdata[7:0];
         if (wr_sec)
            secure_q <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Page buffer and update flags
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < FPBP_PAGE_BYTES; g++) begin : g_buf
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               buf_q[g] <= 8'h00;
               upd_q[g] <= 1'b0;
            end else if (cmd_load) begin
               buf_q[g] <= 8'h00;
               upd_q[g] <= 1'b0;
            end else if (wr_dat && adrl_q[5:0] == 6'(g)) begin
               buf_q[g] <= pwdata[7:0];
               upd_q[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------
   wire logic start_ok = cmd_ep & ~flash_brownout_detect & ~sec_blocked;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q  <= FPBP_IDLE;
         cnt_q <= 23'h000000;
         idx_q <= 7'h00;
      end else begin
         case (st_q)
            FPBP_IDLE: begin
               if (start_ok) begin
                  st_q  <= FPBP_ERASE;
                  cnt_q <= 23'(ERASE_CYC - 1);
                  idx_q <= 7'h00;
               end
            end
            FPBP_ERASE: begin
               if (abort_ev)
                  st_q <= FPBP_IDLE;
               else if (cnt_done) begin
                  st_q  <= FPBP_PROG;
                  cnt_q <= 23'(PROG_CYC - 1);
               end else
                  cnt_q <= cnt_q - 23'h000001;
            end
            FPBP_PROG: begin
               // Byte walk must fit inside the program phase
               if (idx_q < 7'h40)
                  idx_q <= idx_q + 7'h01;
               if (abort_ev || cnt_done)
                  st_q <= FPBP_IDLE;
               else
                  cnt_q <= cnt_q - 23'h000001;
            end
            default: st_q <= FPBP_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status: command write clears, events set (set wins)
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= FPBP_CMDSTAT_RST[3:0];
      end else begin
         logic [3:0] s;
         s = wr_cmd ? 4'h0 : stat_q;
         if (cmd_ep && sec_blocked)
            s[FPBP_SV_BIT] = 1'b1;
         if (cmd_ep && flash_brownout_detect)
            s[FPBP_HVA_BIT] = 1'b1;
         if (busy && irq_pending)
            s[FPBP_OI_BIT] = 1'b1;
         if (busy && abort_ev)
            s[FPBP_HVA_BIT] = 1'b1;
         if (busy && hv_generator_error)
            s[FPBP_HVE_BIT] = 1'b1;
         stat_q <= s;
      end
   end

   // ----------------------------------------------------------------
   // Flash array drive: only flagged bytes are written
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_program_idle <= 1'b0;
         flash_erase_en   <= 1'b0;
         flash_program_en <= 1'b0;
         flash_byte_index <= 8'h00;
         flash_byte_data  <= 8'h00;
         flash_byte_we    <= 1'b0;
         flash_page_addr  <= 16'h0000;
      end else begin
         cpu_program_idle <= (st_q == FPBP_IDLE) ? start_ok
                           : ~(abort_ev | (cnt_done & st_q == FPBP_PROG));
         flash_erase_en   <= (st_q == FPBP_ERASE) & ~abort_ev;
         flash_program_en <= (st_q == FPBP_PROG) & ~abort_ev;
         flash_page_addr  <= {adrh_q, adrl_q[7:6], 6'h00};
         flash_byte_index <= {2'b00, idx_q[5:0]};
         flash_byte_data  <= buf_q[idx_q[5:0]];
         flash_byte_we    <= (st_q == FPBP_PROG) & ~idx_q[6] & upd_q[idx_q[5:0]]
                           & ~abort_ev;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_clear;
      @(posedge pclk) disable iff (!presetn) cmd_load |=> (upd_q == 64'h0);
   endproperty
   a_clear: assert property (p_clear) else $error("Load left flags");

   property p_cmd_clr;
      @(posedge pclk) disable iff (!presetn)
         (wr_cmd && !cmd_ep && !busy) |=> (stat_q == 4'h0);
   endproperty
   a_cmd_clr: assert property (p_cmd_clr) else $error("Status not cleared");

   property p_store;
      @(posedge pclk) disable iff (!presetn)
         wr_dat |=> upd_q[$past(adrl_q[5:0])];
   endproperty
   a_store: assert property (p_store) else $error("Flag not set");

   property p_inc;
      @(posedge pclk) disable iff (!presetn)
         (wr_dat && !wr_adl) |=> adrl_q == {$past(adrl_q[7:6]), $past(adrl_q[5:0]) + 6'h01};
   endproperty
   a_inc: assert property (p_inc) else $error("Address not incremented");

   // State and held processor appear on the same edge
   sequence s_started;
      (st_q == FPBP_ERASE) && cpu_program_idle;
   endsequence

   property p_start;
      @(posedge pclk) disable iff (!presetn) start_ok |=> s_started;
   endproperty
   a_start: assert property (p_start) else $error("Cycle did not start");

   property p_abort;
      @(posedge pclk) disable iff (!presetn)
         (busy && irq_pending) |=> (st_q == FPBP_IDLE) && stat_q[FPBP_OI_BIT];
   endproperty
   a_abort: assert property (p_abort) else $error("Interrupt did not abort");

   property p_bod;
      @(posedge pclk) disable iff (!presetn)
         (cmd_ep && flash_brownout_detect) |=> (st_q == FPBP_IDLE);
   endproperty
   a_bod: assert property (p_bod) else $error("Brown-out did not block");

   property p_secure;
      @(posedge pclk) disable iff (!presetn)
         (cmd_ep && sec_blocked) |=> (st_q == FPBP_IDLE) && stat_q[FPBP_SV_BIT];
   endproperty
   a_secure: assert property (p_secure) else $error("Secured page not refused");

   property p_busy_ign;
      @(posedge pclk) disable iff (!presetn)
         (busy && wr && hit(paddr, FPBP_ADRL_OFS)) |=> $stable(adrl_q);
   endproperty
   a_busy_ign: assert property (p_busy_ign) else $error("Address changed while busy");

   property p_abort_hva;
      @(posedge pclk) disable iff (!presetn)
         (busy && abort_ev) |=> (st_q == FPBP_IDLE) && stat_q[FPBP_HVA_BIT];
   endproperty
   a_abort_hva: assert property (p_abort_hva) else $error("Abort flag not set");

   property p_we_in_prog;
      @(posedge pclk) disable iff (!presetn)
         flash_byte_we |-> flash_program_en && !flash_erase_en;
   endproperty
   a_we_in_prog: assert property (p_we_in_prog) else $error("Strobe outside program");

   property p_release;
      @(posedge pclk) disable iff (!presetn)
         (st_q == FPBP_PROG && cnt_done && !abort_ev) |=> !cpu_program_idle && !busy;
   endproperty
   a_release: assert property (p_release) else $error("Processor not released");
endmodule
`default_nettype wire

// [tb/fpbp_flash_model.sv]
// Behavioural flash array seen from the programmer's byte strobe side
`timescale 1ns/1ps
`default_nettype none
module fpbp_flash_model
   import fpbp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        flash_erase_en,
   input  wire logic        flash_program_en,
   input  wire logic [7:0]  flash_byte_index,
   input  wire logic [7:0]  flash_byte_data,
   input  wire logic        flash_byte_we,
   input  wire logic [15:0] flash_page_addr,
   output logic [511:0]     img,
   output logic [15:0]      page_seen,
   output int               we_cnt,
   output int               bad_cnt
);
   // Only the strobed bytes of the page change; a strobe in erase is a fault
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         img <= '0;
         page_seen <= '0;
         we_cnt <= 0;
         bad_cnt <= 0;
      end else if (flash_byte_we) begin
         img[flash_byte_index[5:0]*8 +: 8] <= flash_byte_data;
         page_seen <= flash_page_addr;
         we_cnt <= we_cnt + 1;
         if (flash_erase_en || !flash_program_en) bad_cnt <= bad_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [tb/fpbp_tb_top.sv]
// Self-checking bench for the flash page buffer programmer
`timescale 1ns/1ps
`default_nettype none
module fpbp_tb_top;
   import fpbp_pkg::*;
   localparam int EC = 100;
   localparam int PC = 100;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, e, irq = 1'b0, bod = 1'b0, high_voltage_error_flag = 1'b0;
   logic        idle, ers, prg, bwe;
   logic [7:0]  bidx, bdat, ex_img [0:63], cur;
   logic [15:0] paddr_f, page_seen, ex_page;
   logic [63:0] ex_flag;
   logic [511:0] img;
   int          we_cnt, bad_cnt, busy_cyc, ers_cyc, prg_cyc, miscompares = 0, checks = 0;
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (idle === 1'b1) busy_cyc <= busy_cyc + 1;
   always @(posedge pclk) if (ers === 1'b1) ers_cyc <= ers_cyc + 1;
   always @(posedge pclk) if (prg === 1'b1) prg_cyc <= prg_cyc + 1;
   fpbp_top #(.ERASE_CYC(EC), .PROG_CYC(PC)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_pending(irq),
      .flash_brownout_detect(bod), .hv_generator_error(high_voltage_error_flag), .cpu_program_idle(idle),
      .flash_erase_en(ers), .flash_program_en(prg), .flash_byte_index(bidx),
      .flash_byte_data(bdat), .flash_byte_we(bwe), .flash_page_addr(paddr_f));
   fpbp_flash_model flash (.pclk(pclk), .presetn(presetn), .flash_erase_en(ers),
      .flash_program_en(prg), .flash_byte_index(bidx), .flash_byte_data(bdat),
      .flash_byte_we(bwe), .flash_page_addr(paddr_f), .img(img), .page_seen(page_seen),
      .we_cnt(we_cnt), .bad_cnt(bad_cnt));
   function automatic logic [7:0] next_adr(input logic [7:0] a);
      return {a[7:6], a[5:0] + 6'h01};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ----------------------------------------------------------------
   // APB master: request held until pready is sampled high
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin @(posedge pclk); n++; end
      if (pready !== 1'b1) begin
         miscompares++;
         $display("[ERR] %0t no pready", $time);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
      chk({31'h0, e}, 32'h0);
   endtask
   task automatic wait_idle(input logic v, input int lim);
      int n;
      n = 0;
      while (idle !== v && n < lim) begin @(posedge pclk); n++; end
      chk({31'h0, idle}, {31'h0, v});
   endtask
   // Clear, set the page, load n bytes from lo onward, then, if n > 0, one byte elsewhere
   task automatic load(input logic [7:0] hi, input logic [7:0] lo, input int n);
      logic [7:0] d;
      apb(1'b1, FPBP_CMDSTAT_OFS, {24'h0, FPBP_CMD_LOAD});
      ex_flag = '0;
      ex_page = {hi, lo[7:6], 6'h00};
      apb(1'b1, FPBP_ADRH_OFS, {24'h0, hi});
      apb(1'b1, FPBP_ADRL_OFS, {24'h0, lo});
      cur = lo;
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         apb(1'b1, FPBP_WDATA_OFS, {24'h0, d});
         ex_img[cur[5:0]] = d;
         ex_flag[cur[5:0]] = 1'b1;
         cur = next_adr(cur);
      end
      rd(FPBP_ADRL_OFS, {24'h0, cur});
      if (n > 0) begin
         cur = {lo[7:6], 6'h1b};
         apb(1'b1, FPBP_ADRL_OFS, {24'h0, cur});
         ex_img[cur[5:0]] = 8'ha5;
         ex_flag[cur[5:0]] = 1'b1;
         apb(1'b1, FPBP_WDATA_OFS, 32'hffff_ffa5);
         cur = next_adr(cur);
      end
   endtask
   // Mode 0 normal, 1 interrupt abort, 2 generator error, 3 refused
   task automatic ep(input int mode, input logic [31:0] st);
      int w0;
      w0 = we_cnt;
      busy_cyc = 0;
      ers_cyc = 0;
      prg_cyc = 0;
      apb(1'b1, FPBP_CMDSTAT_OFS, {24'h0, FPBP_CMD_EP});
      if (mode == 3) begin
         repeat (4) @(posedge pclk);
         chk({31'h0, idle}, 32'h0);
      end else begin
         wait_idle(1'b1, 4);
         apb(1'b1, FPBP_ADRL_OFS, 32'h0000_003f);
         // Interrupt lands in the erase or the program phase
         repeat (20 + (mode == 1 ? $urandom % 160 : 0)) @(posedge pclk);
         irq <= (mode == 1);
         high_voltage_error_flag <= (mode == 2);
         @(posedge pclk);
         high_voltage_error_flag <= 1'b0;
         wait_idle(1'b0, EC + PC + 10);
         irq <= 1'b0;
         rd(FPBP_ADRL_OFS, {24'h0, cur});
      end
      rd(FPBP_CMDSTAT_OFS, st);
      if (mode == 0) begin
         chk(32'(busy_cyc >= EC + PC - 1 && busy_cyc <= EC + PC + 2), 32'h1);
         chk(32'(ers_cyc), 32'(EC));
         chk(32'(prg_cyc), 32'(PC));
         chk(32'(we_cnt - w0), 32'($countones(ex_flag)));
         for (int i = 0; i < 64; i++)
            if (ex_flag[i]) chk({24'h0, img[i*8 +: 8]}, {24'h0, ex_img[i]});
         if (ex_flag != '0) chk({16'h0, page_seen}, {16'h0, ex_page});
      end
      if (mode == 3) chk(32'(we_cnt - w0), 32'h0);
   endtask
   task automatic give_verdict();
      chk(32'(bad_cnt), 32'h0);
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      miscompares++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hc73d));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(FPBP_CMDSTAT_OFS, {24'h0, FPBP_CMDSTAT_RST});
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      load(8'h05, 8'hbe, 4);
      ep(0, 32'h0);
      load(8'h1e, {2'($urandom), 6'h00}, 1 + ($urandom % 8));
      ep(1, 32'h9);
      apb(1'b1, FPBP_CMDSTAT_OFS, 32'h0000_0055);
      rd(FPBP_CMDSTAT_OFS, 32'h0);
      load(8'h02, 8'h40, 0);
      ep(0, 32'h0);
      load(8'h03, 8'h80, 2);
      ep(2, 32'h1 << FPBP_HVE_BIT);
      bod <= 1'b1;
      load(8'h03, 8'h80, 2);
      ep(3, 32'h1 << FPBP_HVA_BIT);
      bod <= 1'b0;
      apb(1'b1, FPBP_SECURE_OFS, 32'h1);
      load(8'h01, 8'hc0, 3);
      ep(3, 32'h1 << FPBP_SV_BIT);
      give_verdict();
   end
endmodule
`default_nettype wire
